// File: design/ihp_defines.svh
// Purpose: constants for the half-rate packet builder
// Assumes: included by bare name
// Notes: octet numbering 1..16, bit 8 is msb
`ifndef IHP_DEFINES_SVH
`define IHP_DEFINES_SVH
`define IHP_NUM_BITS       111
`define IHP_IDX_W          7
`define IHP_PKT_BITS       128
`define IHP_FTI_PATTERN    8'h00DF
`define IHP_FT_1265        4'h2
`define IHP_FT_885         4'h1
`define IHP_FT_660         4'h0
`define IHP_FQI_VALUE      1'b1
`define IHP_PAD_BITS       4
`define IHP_FT_W           4
`define IHP_OCTET_W        8
`define IHP_NUM_OCTETS     16
`define IHP_FT_POS         8
`define IHP_FQI_POS        12
`define IHP_SPEECH_POS     13
`define IHP_PAD_POS        124
`endif

// File: design/ihp_pkg.sv
// Purpose: types for the half-rate packet builder
// Assumes: nothing
// Notes: packet is msb first, octet 1 in the top byte
package ihp_pkg;
    typedef enum logic [1:0] {
        IHP_MODE_660,
        IHP_MODE_885,
        IHP_MODE_1265,
        IHP_MODE_BAD
    } ihp_mode_e;
    typedef struct packed {
        logic [7:0]   frame_type_id;
        logic [3:0]   frame_type;
        logic         frame_quality_indicator;
        logic [110:0] speech;
        logic [3:0]   pad;
    } ihp_pkt_s;
    typedef struct packed {
        logic [110:0] bits;
        ihp_mode_e    mode;
    } ihp_src_s;
endpackage : ihp_pkg

// File: design/ihp_reorder.sv
// Purpose: priority reordering of the source bits
// Assumes: tables are loaded as constants by parameter
// Notes: src bit 0 is the first generated source bit
`include "ihp_defines.svh"
module ihp_reorder #(
    parameter logic [776:0] TABLE0 = '0,
    parameter logic [776:0] TABLE1 = '0,
    parameter logic [776:0] TABLE2 = '0
) (
    input  wire logic [110:0]     src,
    input  wire ihp_pkg::ihp_mode_e mode,
    output logic [110:0]          data
);
    function automatic logic [6:0] lookup(input logic [776:0] t,
                                          input int j);
        lookup = t[j*`IHP_IDX_W +: `IHP_IDX_W];
    endfunction : lookup

    genvar j;
    generate
        for (j = 0; j < `IHP_NUM_BITS; j++) begin : g_bit
            always_comb begin
                unique case (mode)
                    ihp_pkg::IHP_MODE_1265:
                        data[j] = src[lookup(TABLE2, j)];
                    ihp_pkg::IHP_MODE_885:
                        data[j] = src[lookup(TABLE1, j)];
                    ihp_pkg::IHP_MODE_660:
                        data[j] = src[lookup(TABLE0, j)];
                    default:
                        data[j] = 1'b0;
                endcase
            end
        end
    endgenerate
endmodule : ihp_reorder

// File: design/ihp_packer.sv
// Purpose: builds the 16-octet interoperable half-rate packet
// Assumes: source holds only bits that fit the frame, in order
// Notes: table entry j is the zero-based source index (table+1 - 1)
// Notes: mode code 3 is taken but yields no packet
// Notes: a stalled packet holds until the sink takes it
// Assumes: source and sink both on CLK, no synchronisers
// Contract
// - source bits in generation order, excess codebook dropped
// - 12.65 mode reorders by table two
// - 8.85 mode reorders by table one
// - first octet holds frame type identifier
// - 12.65 frame type code 0010
// - 8.85 frame type code 0001
// - quality indicator bit set to one
// - speech bits msb first from octet two
// - 6.60 mode table zero, code 0000
`include "ihp_defines.svh"
module ihp_packer #(
    parameter logic [776:0] TABLE0 = '0,
    parameter logic [776:0] TABLE1 = '0,
    parameter logic [776:0] TABLE2 = '0
) (
    input  wire logic               CLK,
    input  wire logic               RESETN,
    input  wire ihp_pkg::ihp_src_s  SRC,
    input  wire logic               SRC_VALID,
    output logic                    SRC_READY,
    output ihp_pkg::ihp_pkt_s       PKT,
    output logic                    PKT_VALID,
    input  wire logic               PKT_READY
);

    // packet field that a bit position belongs to
    typedef enum logic [2:0] {
        IHP_FLD_ID,
        IHP_FLD_TYPE,
        IHP_FLD_QUALITY,
        IHP_FLD_SPEECH,
        IHP_FLD_PAD
    } ihp_field_e;

    // reordered speech bits, D[0] first
    logic [`IHP_NUM_BITS-1:0]   data;

    // mode decode results
    logic [`IHP_FT_W-1:0]       ft_code;
    logic                       mode_ok;

    // handshake terms
    logic                       take;
    logic                       load;

    // next octets, octet 1 at index 0
    logic [`IHP_OCTET_W-1:0]    octet_next [`IHP_NUM_OCTETS];
    // stored octets and their flat view
    logic [`IHP_OCTET_W-1:0]    pkt_octet [`IHP_NUM_OCTETS];
    logic [`IHP_PKT_BITS-1:0]   pkt_flat;

    // legal interoperable modes only
    function automatic logic is_legal(
        input ihp_pkg::ihp_mode_e m
    );
        unique case (m)
            ihp_pkg::IHP_MODE_660: begin
                is_legal = 1'b1;
            end
            ihp_pkg::IHP_MODE_885: begin
                is_legal = 1'b1;
            end
            ihp_pkg::IHP_MODE_1265: begin
                is_legal = 1'b1;
            end
            default: begin
                is_legal = 1'b0;
            end
        endcase
    endfunction : is_legal

    // frame type code per mode
    function automatic logic [`IHP_FT_W-1:0] frame_type_of(
        input ihp_pkg::ihp_mode_e m
    );
        unique case (m)
            ihp_pkg::IHP_MODE_1265: begin
                frame_type_of = `IHP_FT_1265;
            end
            ihp_pkg::IHP_MODE_885: begin
                frame_type_of = `IHP_FT_885;
            end
            ihp_pkg::IHP_MODE_660: begin
                frame_type_of = `IHP_FT_660;
            end
            default: begin
                frame_type_of = `IHP_FT_660;
            end
        endcase
    endfunction : frame_type_of

    // field of packet bit pos, counted from the msb
    function automatic ihp_field_e field_of(
        input int pos
    );
        if (pos < `IHP_FT_POS) begin
            field_of = IHP_FLD_ID;
        end else if (pos < `IHP_FQI_POS) begin
            field_of = IHP_FLD_TYPE;
        end else if (pos == `IHP_FQI_POS) begin
            field_of = IHP_FLD_QUALITY;
        end else if (pos < `IHP_PAD_POS) begin
            field_of = IHP_FLD_SPEECH;
        end else begin
            field_of = IHP_FLD_PAD;
        end
    endfunction : field_of

    // value of octet n, bit 8 of the octet first
    function automatic logic [`IHP_OCTET_W-1:0] octet_value(
        input int                       n,
        input logic [`IHP_FT_W-1:0]     ft,
        input logic [`IHP_NUM_BITS-1:0] d
    );
        logic [`IHP_OCTET_W-1:0] fti;
        int                      pos;
        int                      msb;
        fti         = `IHP_FTI_PATTERN;
        octet_value = '0;
        for (int b = 0; b < `IHP_OCTET_W; b++) begin
            msb = `IHP_OCTET_W - 1 - b;
            pos = n * `IHP_OCTET_W + b;
            unique case (field_of(pos))
                IHP_FLD_ID: begin
                    octet_value[msb] = fti[msb];
                end
                IHP_FLD_TYPE: begin
                    octet_value[msb] = ft[`IHP_FQI_POS - 1 - pos];
                end
                IHP_FLD_QUALITY: begin
                    octet_value[msb] = `IHP_FQI_VALUE;
                end
                IHP_FLD_SPEECH: begin
                    octet_value[msb] = d[pos - `IHP_SPEECH_POS];
                end
                IHP_FLD_PAD: begin
                    octet_value[msb] = 1'b0;
                end
            endcase
        end
    endfunction : octet_value

    // top bit of octet n within the flat packet
    function automatic int octet_msb(
        input int n
    );
        octet_msb = `IHP_PKT_BITS - 1 - n * `IHP_OCTET_W;
    endfunction : octet_msb

    // priority reordering
    ihp_reorder #(
        .TABLE0 (TABLE0),
        .TABLE1 (TABLE1),
        .TABLE2 (TABLE2)
    ) u_reorder (
        .src  (SRC.bits),
        .mode (SRC.mode),
        .data (data)
    );

    // mode decode
    assign mode_ok = is_legal(SRC.mode);
    assign ft_code = frame_type_of(SRC.mode);

    // free slot, or the held packet leaves at this edge
    assign SRC_READY = !PKT_VALID || PKT_READY;
    assign take      = SRC_VALID && SRC_READY;
    assign load      = take && mode_ok;

    // next octets, built field by field
    genvar k;
    generate
        for (k = 0; k < `IHP_NUM_OCTETS; k++) begin : g_next
            always_comb begin
                octet_next[k] = octet_value(k, ft_code, data);
            end
        end
    endgenerate

    // valid flag, moves only when the slot is free or its packet leaves
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PKT_VALID <= 1'b0;
        end else if (SRC_READY) begin
            PKT_VALID <= load;
        end
    end

    // octet storage, loaded whole on a legal take
    generate
        for (k = 0; k < `IHP_NUM_OCTETS; k++) begin : g_store
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    pkt_octet[k] <= '0;
                end else if (load) begin
                    pkt_octet[k] <= octet_next[k];
                end
            end
        end
    endgenerate

    // flat view of the stored octets
    always_comb begin
        pkt_flat = '0;
        for (int n = 0; n < `IHP_NUM_OCTETS; n++) begin
            pkt_flat[octet_msb(n) -: `IHP_OCTET_W] = pkt_octet[n];
        end
    end

    // packet leaves straight from the octet flops
    assign PKT = ihp_pkg::ihp_pkt_s'(pkt_flat);
endmodule : ihp_packer

// File: test/ihp_chk_checker.sv
// Purpose: packet port checks
// Assumes: one clock domain
// Notes: bound to the packer from tb
module ihp_chk (
    input logic              CLK,
    input logic              RESETN,
    input logic              SRC_VALID,
    input logic              SRC_READY,
    input logic              PKT_VALID,
    input logic              PKT_READY,
    input ihp_pkg::ihp_src_s SRC,
    input ihp_pkg::ihp_pkt_s PKT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    wire       v = PKT_VALID;
    wire       t = SRC_VALID && SRC_READY;
    wire [1:0] m = SRC.mode;
    AST_ID: assert property (v |-> PKT[127:120] == 8'hDF)
        else $error("id");
    AST_FQI: assert property (v |-> PKT[115])
        else $error("fqi");
    AST_PAD: assert property (v |-> PKT[3:0] == 4'h0)
        else $error("pad");
    AST_M0: assert property (t && m == 0 |=> v && PKT[119:116] == 4'h0)
        else $error("m0");
    AST_M1: assert property (t && m == 1 |=> v && PKT[119:116] == 4'h1)
        else $error("m1");
    AST_M2: assert property (t && m == 2 |=> v && PKT[119:116] == 4'h2)
        else $error("m2");
    AST_BAD: assert property (t && m == 3 |=> !v)
        else $error("bad");
    AST_HOLD: assert property (v && !PKT_READY |=> v && $stable(PKT))
        else $error("hold");
    cover property (t && m == 3);
    cover property (v && !PKT_READY);
    cover property (t && v && PKT_READY);
endmodule : ihp_chk

// File: test/ihp_sink.sv
// Purpose: channel sink
// Assumes: none
// Notes: slow takes one in three
module ihp_sink (
    input  logic CLK,
    input  logic slow,
    output logic ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] n = 2'h0;
    always @(posedge CLK) n <= (n == 2'h2) ? 2'h0 : n + 2'h1;
    assign ready = !slow || n == 2'h0;
endmodule : ihp_sink

// File: test/tb.sv
// Purpose: packer bench
// Assumes: toy tables
// Notes: sink stalls
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RESETN = 0, SRC_VALID = 0, slow = 0;
    logic SRC_READY, PKT_VALID, PKT_READY;
    ihp_pkg::ihp_src_s SRC = '0;
    ihp_pkg::ihp_pkt_s PKT, q[$];
    logic [3:0] rf[4] = '{4'h0, 4'h1, 4'h2, 4'h0};
    int err_total = 0, num_checks = 0;
    function automatic logic [776:0] mk(int k);
        for (int j = 0; j < 111; j++) mk[7*j+:7] = 7'((j*k+j+k) % 111);
    endfunction : mk
    task automatic bad(string s);
        err_total++;
        $display("ERROR %0t %s", $time, s);
    endtask : bad
    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic send(int i);
        logic [110:0] b = 111'({28{4'(i + 3)}});
        logic [776:0] t = mk(i % 4);
        ihp_pkg::ihp_pkt_s e = {8'hDF, rf[i % 4], 1'b1, 111'h0, 4'h0};
        for (int j = 0; j < 111; j++) e.speech[110-j] = b[t[7*j+:7]];
        SRC <= ihp_pkg::ihp_src_s'({b, 2'(i)});
        SRC_VALID <= 1;
        do @(negedge CLK); while (SRC_READY !== 1'b1);
        if (i % 4 != 3) q.push_back(e);
        @(posedge CLK);
    endtask : send
    always #50 CLK = ~CLK;
    always @(posedge CLK) if (RESETN && PKT_VALID && PKT_READY) begin
        num_checks++;
        if (q.size() == 0 || PKT !== q.pop_front()) bad("packet");
    end
    ihp_packer #(.TABLE0(mk(0)), .TABLE1(mk(1)), .TABLE2(mk(2))) dut (
        .CLK(CLK), .RESETN(RESETN), .SRC(SRC), .SRC_VALID(SRC_VALID),
        .SRC_READY(SRC_READY), .PKT(PKT), .PKT_VALID(PKT_VALID),
        .PKT_READY(PKT_READY));
    ihp_sink sink (.CLK(CLK), .slow(slow), .ready(PKT_READY));
    initial begin
        repeat (20) @(posedge CLK);
        RESETN <= 1;
        for (int i = 0; i < 16; i++) begin
            slow <= i[3];
            send(i);
        end
        SRC_VALID <= 0;
        repeat (9) @(posedge CLK);
        num_checks++;
        if (q.size() != 0) bad("lost");
        send(2);
        SRC_VALID <= 0;
        RESETN <= 0;
        #1;
        num_checks++;
        if (PKT_VALID !== 1'b0 || SRC_READY !== 1'b1) bad("reset");
        num_checks++;
        if (PKT !== '0) bad("reset data");
        q.delete();
        repeat (2) @(posedge CLK);
        RESETN <= 1;
        send(1);
        SRC_VALID <= 0;
        repeat (9) @(posedge CLK);
        num_checks++;
        if (q.size() != 0) bad("lost after reset");
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge CLK);
        bad("timeout");
        tally_and_finish;
    end
endmodule : tb
bind ihp_packer ihp_chk chk (.CLK(CLK), .RESETN(RESETN), .SRC(SRC),
    .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY), .PKT(PKT),
    .PKT_VALID(PKT_VALID), .PKT_READY(PKT_READY));
